// ---- pkg/emss_map.svh ----
// Constants for the external memory strobe and select block.
// Assumes a 125 MHz system clock and a synchronous active-high reset.
// Function
// - Read strobe low for each read cycle, high otherwise while driven.
// - Data pins released as inputs while read strobe low.
// - Read data captured as the read strobe returns high.
// - Store strobe low in write cycles, data pins drive write data.
// - Drive-hold bit clear tri-states read and store strobes when idle.
// - Drive-hold bit clear tri-states chip select zero when idle.
// - Control-pin pull-up disable bit removes strobe pull-ups.
// - Chip select zero driven low for program memory accesses.
// - Out of reset chip select zero acts as program memory select.
// - Select pin may be port D pin eight, direction programmable.
// - Clearing port D pull-up bit 8 drops select pin pull-up.
// - Data memory select, chip select one, low for data accesses.
`ifndef EMSS_MAP_SVH
`define EMSS_MAP_SVH
`define EMSS_DATA_W 16
`define EMSS_ADDR_W 17
`define EMSS_PD_BIT 8
`define EMSS_STROBE_CYC 2'h2
`define EMSS_ZERO_CNT 2'h0
`define EMSS_ONE_CNT 2'h1
`endif

// ---- pkg/emss_pkg.sv ----
// Types for the external memory strobe and select block.
// Assumes the constant header is on the include path.
package emss_pkg;
	typedef enum logic [1:0] {EMSS_IDLE, EMSS_RD, EMSS_WR, EMSS_END} emss_state_e;
endpackage : emss_pkg

// ---- pkg/emss_pin_if.sv ----
// Bundle carrying one tri-state pin's output, enable and pull-up.
// Assumes the top module resolves nothing; pads sit outside.
`timescale 1ns/1ns
interface emss_pin_if;
	logic o;
	logic oe;
	logic pu;
	modport drv (output o, output oe, output pu);
	modport use_side (input o, input oe, input pu);
endinterface : emss_pin_if

// ---- logic/emss_pin_ctl.sv ----
// Output stage for one active-low control pin: drive, float or GPIO.
// Assumes inputs are synchronous to clock.
`timescale 1ns/1ns
module emss_pin_ctl
(
	input wire logic active,
	input wire logic asserted,
	input wire logic drive_hold,
	input wire logic gpio_mode,
	input wire logic gpio_out,
	input wire logic gpio_dir,
	input wire logic pu_en,
	emss_pin_if.drv pin
);
	always_comb
	begin
		if (gpio_mode)
		begin
			pin.o = gpio_out;
			pin.oe = gpio_dir;
		end
		else
		begin
			pin.o = ~asserted;
			// Floating when idle without hold lets pull-ups define the level
			pin.oe = active | drive_hold;
		end
		pin.pu = pu_en;
	end
endmodule : emss_pin_ctl

// ---- logic/emss_top.sv ----
// Strobe, select and data turnaround for the external memory bus.
// Assumes one request pulse at a time; static RAM or ROM outside.
`timescale 1ns/1ns
`include "emss_map.svh"
module emss_top
	import emss_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic req_prog,
	input wire logic [`EMSS_ADDR_W-1:0] req_addr,
	input wire logic [`EMSS_DATA_W-1:0] req_wdata,
	input wire logic bus_drive_hold,
	input wire logic ctrl_pullup_disable,
	input wire logic port_d_pin_eight_gpio,
	input wire logic port_d_pin_eight_dir,
	input wire logic port_d_pin_eight_out,
	input wire logic [`EMSS_DATA_W-1:0] port_d_pullup_reg,
	input wire logic [`EMSS_DATA_W-1:0] data_in,
	output logic req_busy,
	output logic rd_valid,
	output logic [`EMSS_DATA_W-1:0] rd_data,
	output logic [`EMSS_ADDR_W-1:0] addr_out,
	output logic addr_oe,
	output logic [`EMSS_DATA_W-1:0] data_out,
	output logic data_oe,
	output logic read_strobe_n,
	output logic read_strobe_oe,
	output logic store_strobe_n,
	output logic store_strobe_oe,
	output logic strobe_pullup_en,
	output logic chip_select_zero_n,
	output logic chip_select_zero_oe,
	output logic chip_select_zero_pullup_en,
	output logic data_memory_select_n,
	output logic data_memory_select_oe
);
	emss_state_e state_q, state_d;
	logic [1:0] cnt_q, cnt_d;
	logic prog_q, prog_d;
	logic [`EMSS_ADDR_W-1:0] addr_q, addr_d;
	logic [`EMSS_DATA_W-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
	logic rvalid_q, rvalid_d;
	logic rd_n_q, rd_oe_q, wr_n_q, wr_oe_q, pu_q;
	logic cs0_n_q, cs0_oe_q, cs0_pu_q, ds_n_q, ds_oe_q;
	logic dat_oe_q, addr_oe_q;
	logic busy_q, busy_d, dat_oe_d, addr_oe_d;
	logic rd_act, wr_act, cyc_act;
	emss_pin_if rd_pin();
	emss_pin_if wr_pin();
	emss_pin_if cs0_pin();
	emss_pin_if ds_pin();

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		prog_d = prog_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		rvalid_d = 1'b0;
		case (state_q)
			EMSS_IDLE:
			begin
				if (req_valid)
				begin
					prog_d = req_prog;
					addr_d = req_addr;
					wdata_d = req_wdata;
					cnt_d = `EMSS_STROBE_CYC;
					// One state at a time keeps the strobes exclusive
					state_d = req_write ? EMSS_WR : EMSS_RD;
				end
			end
			EMSS_RD, EMSS_WR:
			begin
				if (cnt_q == `EMSS_ONE_CNT)
				begin
					if (state_q == EMSS_RD)
					begin
						// Sampled on the edge that raises the strobe
						rdata_d = data_in;
						rvalid_d = 1'b1;
					end
					state_d = EMSS_END;
				end
				cnt_d = cnt_q - `EMSS_ONE_CNT;
			end
			// Turnaround cycle: strobe high, data still held for the memory after a write
			EMSS_END: state_d = EMSS_IDLE;
			default: state_d = EMSS_IDLE;
		endcase
	end

	assign rd_act = (state_d == EMSS_RD);
	assign wr_act = (state_d == EMSS_WR);
	assign cyc_act = rd_act | wr_act | (state_d == EMSS_END);
	// Busy is registered so the request side sees a flop, not decode
	assign busy_d = (state_d != EMSS_IDLE);
	// Data pins released during reads, driven only on writes
	assign dat_oe_d = wr_act
		| (state_d == EMSS_END && state_q == EMSS_WR);
	// Drive-hold keeps the address up between accesses
	assign addr_oe_d = cyc_act | bus_drive_hold;

	emss_pin_ctl u_rd
	(
		.active(cyc_act),
		.asserted(rd_act),
		.drive_hold(bus_drive_hold),
		.gpio_mode(1'b0),
		.gpio_out(1'b0),
		.gpio_dir(1'b0),
		.pu_en(~ctrl_pullup_disable),
		.pin(rd_pin.drv)
	);
	emss_pin_ctl u_wr
	(
		.active(cyc_act),
		.asserted(wr_act),
		.drive_hold(bus_drive_hold),
		.gpio_mode(1'b0),
		.gpio_out(1'b0),
		.gpio_dir(1'b0),
		.pu_en(~ctrl_pullup_disable),
		.pin(wr_pin.drv)
	);
	emss_pin_ctl u_cs0
	(
		.active(cyc_act),
		.asserted((rd_act | wr_act) & prog_d),
		.drive_hold(bus_drive_hold),
		.gpio_mode(port_d_pin_eight_gpio),
		.gpio_out(port_d_pin_eight_out),
		.gpio_dir(port_d_pin_eight_dir),
		.pu_en(port_d_pullup_reg[`EMSS_PD_BIT]),
		.pin(cs0_pin.drv)
	);
	emss_pin_ctl u_ds
	(
		.active(cyc_act),
		.asserted((rd_act | wr_act) & ~prog_d),
		.drive_hold(bus_drive_hold),
		.gpio_mode(1'b0),
		.gpio_out(1'b0),
		.gpio_dir(1'b0),
		.pu_en(1'b1),
		.pin(ds_pin.drv)
	);

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			// Chip select zero comes up as program memory select
			state_q <= EMSS_IDLE;
			cnt_q <= `EMSS_ZERO_CNT;
			prog_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
			rdata_q <= '0;
			rvalid_q <= 1'b0;
			rd_n_q <= 1'b1;
			rd_oe_q <= 1'b0;
			wr_n_q <= 1'b1;
			wr_oe_q <= 1'b0;
			pu_q <= 1'b1;
			cs0_n_q <= 1'b1;
			cs0_oe_q <= 1'b0;
			cs0_pu_q <= 1'b1;
			ds_n_q <= 1'b1;
			ds_oe_q <= 1'b0;
			dat_oe_q <= 1'b0;
			addr_oe_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			prog_q <= prog_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
			rd_n_q <= rd_pin.o;
			rd_oe_q <= rd_pin.oe;
			wr_n_q <= wr_pin.o;
			wr_oe_q <= wr_pin.oe;
			pu_q <= rd_pin.pu;
			cs0_n_q <= cs0_pin.o;
			cs0_oe_q <= cs0_pin.oe;
			cs0_pu_q <= cs0_pin.pu;
			ds_n_q <= ds_pin.o;
			ds_oe_q <= ds_pin.oe;
			dat_oe_q <= dat_oe_d;
			addr_oe_q <= addr_oe_d;
			busy_q <= busy_d;
		end
	end

	assign req_busy = busy_q;
	assign rd_valid = rvalid_q;
	assign rd_data = rdata_q;
	assign addr_out = addr_q;
	assign addr_oe = addr_oe_q;
	assign data_out = wdata_q;
	assign data_oe = dat_oe_q;
	assign read_strobe_n = rd_n_q;
	assign read_strobe_oe = rd_oe_q;
	assign store_strobe_n = wr_n_q;
	assign store_strobe_oe = wr_oe_q;
	assign strobe_pullup_en = pu_q;
	assign chip_select_zero_n = cs0_n_q;
	assign chip_select_zero_oe = cs0_oe_q;
	assign chip_select_zero_pullup_en = cs0_pu_q;
	assign data_memory_select_n = ds_n_q;
	assign data_memory_select_oe = ds_oe_q;
endmodule : emss_top

// ---- verification/emss_checker.sv ----
// Pin checks for the strobe and select block.
// Bound into emss_top; one clock, synchronous reset.
`timescale 1ns/1ns
module emss_checker
(
	input wire logic clock,
	input wire logic srst,
	input wire logic req_prog,
	input wire logic rd_valid,
	input wire logic [15:0] rd_data,
	input wire logic [15:0] data_in,
	input wire logic [15:0] data_out,
	input wire logic data_oe,
	input wire logic read_strobe_n,
	input wire logic store_strobe_n,
	input wire logic chip_select_zero_n,
	input wire logic data_memory_select_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	AST_OVL: assert property (read_strobe_n | store_strobe_n)
		else $error("both strobes low");
	AST_RD_IN: assert property (!read_strobe_n |-> !data_oe)
		else $error("driving in read");
	AST_WR_OUT: assert property (!store_strobe_n |-> data_oe)
		else $error("not driving in write");
	AST_RD_LEN: assert property ($fell(read_strobe_n) |=>
		!read_strobe_n ##1 read_strobe_n) else $error("read width");
	AST_WR_LEN: assert property ($fell(store_strobe_n) |=>
		!store_strobe_n ##1 store_strobe_n) else $error("write width");
	AST_RD_CAP: assert property ($rose(read_strobe_n) && !$past(srst)
		|-> rd_valid && rd_data == $past(data_in)) else $error("capture");
	AST_WR_HOLD: assert property ($rose(store_strobe_n) && !$past(srst)
		|-> data_oe && $stable(data_out)) else $error("write hold");
	AST_SEL: assert property ($fell(read_strobe_n & store_strobe_n)
		|-> chip_select_zero_n == !$past(req_prog)
		&& data_memory_select_n == $past(req_prog)) else $error("select");
endmodule : emss_checker
bind emss_top emss_checker u_emss_checker (.*);

// ---- verification/emss_sram_model.sv ----
// Static RAM on the far pins of the strobe block.
// Data pins have pull-ups, so released pins read all ones.
`timescale 1ns/1ns
module emss_sram_model
(
	input wire logic clock,
	input wire logic [16:0] addr_out,
	input wire logic [15:0] data_out,
	input wire logic read_strobe_n,
	input wire logic store_strobe_n,
	input wire logic chip_select_zero_n,
	input wire logic data_memory_select_n,
	output logic [15:0] data_in
);
	logic [15:0] mem [0:255];
	logic [7:0] idx;
	logic sel;
	assign sel = !(chip_select_zero_n & data_memory_select_n);
	assign idx = {chip_select_zero_n, addr_out[6:0]};
	assign data_in = !read_strobe_n && sel ? mem[idx] : 16'hffff;
	// Last word seen before the strobe rises is the one kept
	always @(posedge clock)
		if (!store_strobe_n && sel)
			mem[idx] <= data_out;
endmodule : emss_sram_model

// ---- verification/tb_ext_memory_strobe_select.sv ----
// Bench for the strobe block, SRAM model on the far pins.
// Inputs move 1 ns after each rising edge.
`timescale 1ns/1ns
module tb_ext_memory_strobe_select;
	logic clock, srst, req_valid, req_write, req_prog, req_busy, rd_valid;
	logic [16:0] req_addr, addr_out;
	logic [15:0] req_wdata, port_d_pullup_reg, data_in, rd_data, data_out;
	logic bus_drive_hold, ctrl_pullup_disable, port_d_pin_eight_gpio;
	logic port_d_pin_eight_dir, port_d_pin_eight_out, addr_oe, data_oe;
	logic read_strobe_n, read_strobe_oe, store_strobe_n, store_strobe_oe;
	logic strobe_pullup_en, chip_select_zero_n, chip_select_zero_oe;
	logic chip_select_zero_pullup_en, data_memory_select_n;
	logic data_memory_select_oe;
	int err_count, check_count;
	emss_top u_emss_top (.*);
	emss_sram_model u_emss_sram_model (.*);
	initial
	begin
		clock = 0;
		forever #4 clock = ~clock;
	end
	task tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		err_count += seen !== exp;
		if (seen !== exp)
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
	endtask : chk
	task conclude();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : conclude
	// One pulse, then wait out busy; a stuck busy ends the run
	task acc(input logic w, p, input logic [15:0] d, output logic [15:0] q);
		q = 16'hxxxx;
		{req_valid, req_write, req_prog, req_wdata} = {1'b1, w, p, d};
		tick(1);
		req_valid = 0;
		chk({read_strobe_n, store_strobe_n}, {w, ~w});
		chk({chip_select_zero_n, data_memory_select_n}, {~p, p});
		chk({read_strobe_oe, store_strobe_oe, addr_oe}, 3'h7);
		chk({chip_select_zero_oe, data_memory_select_oe}, 2'h3);
		chk(addr_out, 17'h1_0005);
		chk(data_oe, w);
		for (int i = 0; i < 8 && req_busy !== 1'b0; i++)
		begin
			tick(1);
			if (rd_valid === 1'b1)
				q = rd_data;
		end
		chk(req_busy, 1'b0);
		if (req_busy !== 1'b0)
			conclude();
	endtask : acc
	task t_access(input logic h);
		logic [15:0] q;
		bus_drive_hold = h;
		acc(1, 1, 16'h1234 ^ h, q);
		acc(1, 0, 16'h5678 ^ h, q);
		acc(0, 1, 16'h0000, q);
		chk(q, 16'h1234 ^ h);
		acc(0, 0, 16'h0000, q);
		chk(q, 16'h5678 ^ h);
		chk({read_strobe_oe, store_strobe_oe, addr_oe}, {3{h}});
		chk({chip_select_zero_oe, data_memory_select_oe}, {2{h}});
		chk({data_oe, read_strobe_n, store_strobe_n}, 3'h3);
		chk({strobe_pullup_en, chip_select_zero_pullup_en}, 2'h3);
	endtask : t_access
	task t_pins();
		{ctrl_pullup_disable, port_d_pin_eight_gpio} = 2'h3;
		{port_d_pin_eight_dir, port_d_pullup_reg} = {1'b1, 16'hfeff};
		tick(2);
		chk(strobe_pullup_en, 1'b0);
		chk(chip_select_zero_pullup_en, 1'b0);
		chk({chip_select_zero_oe, chip_select_zero_n}, 2'h2);
		{port_d_pin_eight_dir, port_d_pin_eight_out} = 2'h1;
		tick(1);
		chk({chip_select_zero_oe, chip_select_zero_n}, 2'h1);
	endtask : t_pins
	initial
	begin
		{err_count, check_count, srst} = 65'h1;
		{req_valid, req_write, req_prog, bus_drive_hold} = 4'h0;
		{ctrl_pullup_disable, port_d_pin_eight_gpio} = 2'h0;
		{port_d_pin_eight_dir, port_d_pin_eight_out} = 2'h0;
		{req_addr, req_wdata} = {17'h1_0005, 16'h0000};
		port_d_pullup_reg = 16'hffff;
		tick(20);
		srst = 0;
		t_access(0);
		t_access(1);
		t_pins();
		conclude();
	end
endmodule : tb_ext_memory_strobe_select
